// ===== otgfc_bus_model.sv
// Bus comparator stand-in at the far side of the control block.
// Assumes the bench clock and reset; session end follows the discharge.
`timescale 1ns/1ps
`default_nettype none
module otgfc_bus_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Discharge request and session end comparator.
  input wire logic bus_discharge,
  output logic session_end_flag
);
  logic [3:0] cnt;
  // Session end rises after ten cycles of discharge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else if (!bus_discharge) begin
      cnt <= 4'h0;
    end else if (cnt != 4'ha) begin
      cnt <= cnt + 4'h1;
    end
  end
  assign session_end_flag = (cnt == 4'ha);
endmodule // otgfc_bus_model
`default_nettype wire

// ===== otgfc_consts.svh
// Constants for the OTG function control register block.
// Assumes byte addresses on a 32-bit APB with one register per word.
`ifndef OTGFC_CONSTS_SVH
`define OTGFC_CONSTS_SVH
`define OTGFC_IDX_WRITE 8'h0a
`define OTGFC_IDX_SET 8'h0b
`define OTGFC_IDX_CLEAR 8'h0c
`define OTGFC_RESET_VALUE 8'h06
`define OTGFC_BIT_EXT_SEL 7
`define OTGFC_BIT_EXT_SUPPLY 6
`define OTGFC_BIT_INT_DRIVE 5
`define OTGFC_BIT_CHARGE 4
`define OTGFC_BIT_DISCHARGE 3
`define OTGFC_BIT_MINUS_PD 2
`define OTGFC_BIT_PLUS_PD 1
`endif

// ===== otgfc_pkg.sv
// Types for the OTG function control register block.
// Assumes nothing of its surroundings.
package otgfc_pkg;
  typedef enum logic [2:0] {
    OTGFC_OP_WRITE = 3'b001,
    OTGFC_OP_SET = 3'b010,
    OTGFC_OP_CLEAR = 3'b100
  } otgfc_op_e;
  typedef logic [7:0] otgfc_byte_t;
endpackage

// ===== otgfc_top.sv
// OTG function control register with pin outputs, reached over APB.
// Assumes one 20 MHz clock and inputs synchronous to it.
// Operation
// (RQ1) Reads at write, set and clear addresses all return the register.
// (RQ2) Set address ORs written ones in; clear address removes them.
// (RQ3) Bit 7 picks internal comparator (0) or fault pin (1); resets 0.
// (RQ4) Bit 6 high drives the active-low supply switch low; resets 0.
// (RQ5) Bit 5 requests internal bus drive; optional when bit 6 set.
// (RQ6) Bit 4 charges the bus; link checks discharge and 2 ms SE0 first.
// (RQ7) Link clears discharge bit 3 after session end rises.
// (RQ8) Bit 2 connects the minus line pull-down; resets 1.
// (RQ9) Bit 1 connects the plus line pull-down; resets 1.
// (RQ10) Link writes 0 to reserved bit 0; resets 0.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "otgfc_consts.svh"
module otgfc_top
  import otgfc_pkg::*;
(
  // APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side.
  input wire logic internal_valid,
  input wire logic fault_in,
  input wire logic session_end_flag,
  output logic bus_valid,
  output logic supply_switch_n,
  output logic supply_switch_oe_n,
  output logic internal_supply_drive,
  output logic bus_charge,
  output logic bus_discharge,
  output logic minus_line_pulldown,
  output logic plus_line_pulldown
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic valid;
    logic sw_n;
    logic sw_oe_n;
  } otgfc_state_s;

  otgfc_state_s st;
  otgfc_state_s next_st;
  otgfc_op_e op;
  logic [7:0] upd;
  logic acc;
  logic hit;

  function automatic logic [2:0] decode(input logic [7:0] a);
    unique case (a)
      `OTGFC_IDX_WRITE << 2: decode = 3'h1;
      `OTGFC_IDX_SET << 2: decode = 3'h2;
      `OTGFC_IDX_CLEAR << 2: decode = 3'h4;
      default: decode = 3'h0;
    endcase
  endfunction

  assign hit = (decode(paddr) != 3'h0);
  assign op = otgfc_op_e'(decode(paddr));
  assign acc = psel && penable && !st.ready;

  otgfc_update u_update (
    .op(op),
    .cur(st.ctrl),
    .data(pwdata[7:0]),
    .result(upd)
  );

  always_comb begin
    logic [7:0] c;
    c = st.ctrl;
    next_st = st;
    next_st.ready = acc;
    next_st.err = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (acc) begin
      next_st.err = !hit;
      if (pwrite && hit) begin
        c = upd; // RQ1 RQ2
      end else if (!pwrite && hit) begin
        next_st.rdata = {24'h00_0000, st.ctrl}; // RQ1
      end
    end
    next_st.ctrl = c;
    next_st.valid = st.ctrl[`OTGFC_BIT_EXT_SEL] ? fault_in
                                                : internal_valid; // RQ3
    next_st.sw_n = !c[`OTGFC_BIT_EXT_SUPPLY]; // RQ4
    next_st.sw_oe_n = !c[`OTGFC_BIT_EXT_SUPPLY]; // RQ4
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.ctrl <= `OTGFC_RESET_VALUE; // RQ3 RQ4 RQ5 RQ8 RQ9 RQ10
      st.rdata <= 32'h0000_0000;
      st.ready <= 1'b0;
      st.err <= 1'b0;
      st.valid <= 1'b0;
      st.sw_n <= 1'b1;
      st.sw_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign bus_valid = st.valid;
  assign supply_switch_n = st.sw_n;
  assign supply_switch_oe_n = st.sw_oe_n;
  assign internal_supply_drive = st.ctrl[`OTGFC_BIT_INT_DRIVE]; // RQ5
  assign bus_charge = st.ctrl[`OTGFC_BIT_CHARGE]; // RQ6
  assign bus_discharge = st.ctrl[`OTGFC_BIT_DISCHARGE]; // RQ7
  assign minus_line_pulldown = st.ctrl[`OTGFC_BIT_MINUS_PD]; // RQ8
  assign plus_line_pulldown = st.ctrl[`OTGFC_BIT_PLUS_PD]; // RQ9

  property p_set_write;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == 8'h2c) |=> (st.ctrl == ($past(st.ctrl)
        | $past(pwdata[7:0])));
  endproperty
  a_set_write: assert property (p_set_write) // RQ2
    else $error("set write wrong");

  property p_clear_write;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == 8'h30) |=> (st.ctrl == ($past(st.ctrl)
        & ~$past(pwdata[7:0])));
  endproperty
  a_clear_write: assert property (p_clear_write) // RQ2
    else $error("clear write wrong");

  property p_read_all;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && hit) |=> (prdata[7:0] == $past(st.ctrl)
        && pready);
  endproperty
  a_read_all: assert property (p_read_all) // RQ1
    else $error("read data wrong");

  property p_full_write;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == 8'h28) |=> st.ctrl == $past(pwdata[7:0]);
  endproperty
  a_full_write: assert property (p_full_write) // RQ1
    else $error("full write wrong");

  property p_source;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> bus_valid == ($past(st.ctrl[7]) ? $past(fault_in)
                                          : $past(internal_valid));
  endproperty
  a_source: assert property (p_source) // RQ3
    else $error("valid source wrong");

  property p_switch;
    @(posedge pclk) disable iff (!presetn)
      supply_switch_n == !st.ctrl[6] && supply_switch_oe_n == !st.ctrl[6];
  endproperty
  a_switch: assert property (p_switch) // RQ4
    else $error("switch drive wrong");

  property p_pins;
    @(posedge pclk) disable iff (!presetn)
      {internal_supply_drive, bus_charge, bus_discharge,
       minus_line_pulldown, plus_line_pulldown} == st.ctrl[5:1];
  endproperty
  a_pins: assert property (p_pins) // RQ5
    else $error("pin outputs wrong");

  property p_stable;
    @(posedge pclk) disable iff (!presetn)
      !(acc && pwrite && hit) |=> $stable(st.ctrl);
  endproperty
  a_stable: assert property (p_stable) // RQ8
    else $error("register changed without write");

  property p_pulls_reset;
    @(posedge pclk) $rose(presetn) |-> minus_line_pulldown
      && plus_line_pulldown;
  endproperty
  a_pulls_reset: assert property (p_pulls_reset) // RQ9
    else $error("pull-downs not on after reset");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      acc |=> pready;
  endproperty
  a_answer: assert property (p_answer) // RQ1
    else $error("access not answered after one wait state");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // RQ1
    else $error("ready stood longer than one cycle");

  property p_no_stray_ready;
    @(posedge pclk) disable iff (!presetn)
      !acc |=> !pready && !pslverr;
  endproperty
  a_no_stray_ready: assert property (p_no_stray_ready) // RQ1
    else $error("answer without an access");

  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
      (acc && !hit) |=> pslverr && prdata == 32'h0000_0000
        && $stable(st.ctrl);
  endproperty
  a_refuse: assert property (p_refuse) // RQ1
    else $error("unmapped access not refused");

  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
      (acc && hit) |=> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) // RQ1
    else $error("mapped access flagged as error");

  property p_write_answer;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite) |=> prdata == 32'h0000_0000;
  endproperty
  a_write_answer: assert property (p_write_answer) // RQ1
    else $error("write answer carries data");

  property p_read_upper;
    @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_read_upper: assert property (p_read_upper) // RQ1
    else $error("upper read bits not zero");

  property p_read_keeps;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite) |=> $stable(st.ctrl);
  endproperty
  a_read_keeps: assert property (p_read_keeps) // RQ1
    else $error("read changed the register");

  property p_set_charge;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == (`OTGFC_IDX_SET << 2)
        && pwdata[`OTGFC_BIT_CHARGE]) |=> bus_charge;
  endproperty
  a_set_charge: assert property (p_set_charge) // RQ6
    else $error("charge not started by set");

  property p_set_drive;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == (`OTGFC_IDX_SET << 2)
        && pwdata[`OTGFC_BIT_INT_DRIVE]) |=> internal_supply_drive;
  endproperty
  a_set_drive: assert property (p_set_drive) // RQ5
    else $error("internal drive not requested by set");

  property p_set_plus;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == (`OTGFC_IDX_SET << 2)
        && pwdata[`OTGFC_BIT_PLUS_PD]) |=> plus_line_pulldown;
  endproperty
  a_set_plus: assert property (p_set_plus) // RQ9
    else $error("plus pull-down not connected by set");

  property p_clear_discharge;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == (`OTGFC_IDX_CLEAR << 2)
        && pwdata[`OTGFC_BIT_DISCHARGE]) |=> !bus_discharge;
  endproperty
  a_clear_discharge: assert property (p_clear_discharge) // RQ2
    else $error("discharge not stopped by clear");

  property p_clear_minus;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && paddr == (`OTGFC_IDX_CLEAR << 2)
        && pwdata[`OTGFC_BIT_MINUS_PD]) |=> !minus_line_pulldown;
  endproperty
  a_clear_minus: assert property (p_clear_minus) // RQ8
    else $error("minus pull-down not removed by clear");

  property p_reset_value;
    @(posedge pclk) $rose(presetn) |-> st.ctrl == `OTGFC_RESET_VALUE
      && supply_switch_n && supply_switch_oe_n && !pready;
  endproperty
  a_reset_value: assert property (p_reset_value) // RQ4
    else $error("register or switch wrong after reset");

  c_set: cover property (@(posedge pclk) acc && pwrite && paddr == 8'h2c);
  c_clear: cover property (@(posedge pclk) acc && pwrite && paddr == 8'h30);
  c_read: cover property (@(posedge pclk) acc && !pwrite && hit);
  c_err: cover property (@(posedge pclk) acc && !hit);
  c_session_end: cover property (@(posedge pclk)
    bus_discharge && session_end_flag);
endmodule // otgfc_top
`default_nettype wire

// ===== otgfc_update.sv
// Computes the next control byte for a write, set or clear access.
// Assumes the caller qualifies the access with a completed APB write.
`timescale 1ns/1ps
`default_nettype none
module otgfc_update
  import otgfc_pkg::*;
(
  // Operands.
  input wire otgfc_op_e op,
  input wire logic [7:0] cur,
  input wire logic [7:0] data,
  // Result.
  output logic [7:0] result
);
  always_comb begin
    unique case (op)
      OTGFC_OP_WRITE: result = data;
      OTGFC_OP_SET: result = cur | data; // RQ2
      OTGFC_OP_CLEAR: result = cur & ~data; // RQ2
      default: result = cur;
    endcase
  end
endmodule // otgfc_update
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the OTG function control register block.
// Assumes otgfc_top and otgfc_bus_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, m = 8'h06;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, iv = 0, fi = 0, sef, bv, sw_n, oe_n, drv, chg;
  logic dis, mpd, ppd;
  logic [32:0] q[$];
  logic [32:0] e;
  integer error_cnt = 0, samples_checked = 0, seed = 98, i, k;
  always #25 pclk = ~pclk;
  otgfc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_valid(iv), .fault_in(fi), .session_end_flag(sef),
    .bus_valid(bv), .supply_switch_n(sw_n), .supply_switch_oe_n(oe_n),
    .internal_supply_drive(drv), .bus_charge(chg), .bus_discharge(dis),
    .minus_line_pulldown(mpd), .plus_line_pulldown(ppd));
  otgfc_bus_model far (.pclk(pclk), .presetn(presetn),
    .bus_discharge(dis), .session_end_flag(sef));
  task automatic bad(input string s);
    error_cnt++;
    $display("BAD %0t %s", $time, s);
  endtask
  // Each answer is compared with the oldest noted expectation.
  always @(posedge pclk) if (pready === 1'b1) begin
    e = q.size() ? q.pop_front() : 33'h1_ffff_ffff;
    samples_checked++;
    if ({pslverr, prdata} !== e) bad("apb answer");
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    int n;
    ok = (a == 8'h28 || a == 8'h2c || a == 8'h30);
    q.push_back({!ok, 24'h00_0000, (w || !ok) ? 8'h00 : m});
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= ({$random(seed)} & 32'hffff_ff00) | {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) bad("no ready");
    psel <= 0;
    penable <= 0;
    if (w && ok) case (a)
      8'h28: m = d;
      8'h2c: m = m | d;
      default: m = m & ~d;
    endcase
  endtask
  task automatic pins;
    @(posedge pclk);
    {iv, fi} <= 2'($random(seed));
    repeat (3) @(posedge pclk);
    samples_checked++;
    if ({bv, sw_n, oe_n, drv, chg, dis, mpd, ppd} !==
        {m[7] ? fi : iv, !m[6], !m[6], m[5:1]}) bad("pins");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    bad("timeout");
    stop_test;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 3; i++) apb(0, 8'h28 + 8'(4 * i), 8'h00);
    pins;
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      k = {$random(seed)} % 3;
      apb(1, 8'h28 + 8'(4 * k), 8'($random(seed)) & 8'he6);
      k = {$random(seed)} % 3;
      apb(0, 8'h28 + 8'(4 * k), 8'h00);
      pins;
    end
    $display("test random done");
    apb(1, 8'h2c, 8'h08);
    for (k = 0; k < 50 && sef !== 1'b1; k++) @(posedge pclk);
    if (sef !== 1'b1) bad("no session end");
    apb(1, 8'h30, 8'h08);
    apb(1, 8'h2c, 8'h10);
    pins;
    $display("test pulse done");
    apb(1, 8'h00, 8'hff);
    apb(0, 8'h00, 8'h00);
    apb(0, 8'h30, 8'h00);
    @(posedge pclk);
    presetn <= 0;
    m = 8'h06;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h2c, 8'h00);
    pins;
    $display("test refuse and reset done");
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
